// ===== src/frc_cfg.svh
// Purpose: constants for the fifo reset and offset configuration block
// Assumes: included by its bare name
// Notes:   offsets are byte addresses of 32-bit registers
`ifndef FRC_CFG_SVH
`define FRC_CFG_SVH
`define FRC_DEPTH_DEF      1024
`define FRC_SYNC_CYC       2
`define FRC_PRESET_OFS_8   8
`define FRC_PRESET_OFS_16  16
`define FRC_PRESET_OFS_64  64
`define FRC_ADDR_CTRL      8'h00
`define FRC_ADDR_STATUS    8'h04
`define FRC_ADDR_OFFSETS   8'h08
`define FRC_ADDR_COUNT     8'h0C
`define FRC_CTRL_RST       0
`define FRC_CTRL_BUSW      1
`define FRC_ST_SPACE       0
`define FRC_ST_DATA        1
`define FRC_ST_NEMPTY      2
`define FRC_ST_NFULL       3
`define FRC_ST_MB1         4
`define FRC_ST_MB2         5
`define FRC_ST_FALL_THROUGH_MODE        6
`define FRC_ST_BIGEND      7
`define FRC_ST_PROG        8
`define FRC_ST_SERIAL      9
`define FRC_AXI_OKAY       2'h0
`define FRC_AXI_SLVERR     2'h2
`endif

// ===== src/frc_pkg.sv
// Purpose: types for the fifo reset and offset configuration block
// Assumes: nothing
// Notes:   constants live in frc_cfg.svh
package frc_pkg;
  typedef enum logic [1:0] {FRC_PM_PRESET, FRC_PM_PARALLEL, FRC_PM_SERIAL} frc_prog_t;
  typedef enum logic [1:0] {FRC_S_RESET, FRC_S_SETTLE, FRC_S_PROG, FRC_S_RUN} frc_state_t;
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } frc_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } frc_axi_rsp_t;
  typedef struct packed {
    logic        space_avail_flag;
    logic        data_avail_flag;
    logic        near_empty_flag_n;
    logic        near_full_flag_n;
    logic        mailbox1_full_n;
    logic        mailbox2_full_n;
  } frc_flags_t;
endpackage

// ===== src/frc_reset_cfg.sv
// Operation
// - reset pins accepted anytime, asynchronously
// - reset clears pointers, sets flag levels
// - full reset forces mailbox flags high
// - space flag rises two cycles after reset; here it rises on the fourth edge after the synchronised release
// - reset release captures order, selects, method
// - flush reset keeps offsets, method, mode
// - order pin high sends MSB first
// - order pin low sends LSB first
// - full width bus ignores byte order
// - second edge after release picks mode
// - standard mode delivers words on reads
// - fall-through shows first word unread
// - serial-high with selects loads preset
// - first two writes load far, near
// - offsets accepted zero to depth minus one
// - parallel mode raises space before writes
// - serial bit shifts while enable low
// - stream loads far then near, MSB first
// - space flag high edge after last bit; here it goes high on the second edge after the last bit
// - near-empty low at or below offset
// - flush reset zeroes port b output
//
// Purpose: reset sequencing and offset programming of a synchronous fifo
// Assumes: one clock; reset pins are sampled after a two-flop synchroniser
// Notes:   the word count is a software-visible stand-in for the datapath
`include "frc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module frc_reset_cfg #(
  parameter int DEPTH = `FRC_DEPTH_DEF
) (
  input  wire logic               core_clk_i,
  input  wire logic               reset_i,
  input  wire logic               full_reset_n_1_i,
  input  wire logic               full_reset_n_2_i,
  input  wire logic               flush_reset_n_i,
  input  wire logic               byte_order_timing_sel_i,
  input  wire logic               flag_sel0_serial_data_i,
  input  wire logic               flag_sel1_serial_en_n_i,
  input  wire logic               serial_prog_sel_n_i,
  input  wire logic               port_a_write_i,
  input  wire logic [35:0]        port_a_data_i,
  input  wire frc_pkg::frc_axi_req_t axi_req_i,
  output frc_pkg::frc_axi_rsp_t   axi_rsp_o,
  output frc_pkg::frc_flags_t     flags_o,
  output logic                    fall_through_mode_o,
  output logic                    big_endian_o,
  output logic [35:0]             port_b_data_o
);
  import frc_pkg::*;
  localparam int OW = $clog2(DEPTH);
  localparam int SBITS = 2 * OW;
  initial begin
    if (DEPTH != 1024 && DEPTH != 4096 && DEPTH != 16384)
      $error("depth must be 1024, 4096 or 16384");
  end

  ////////////////////////////////////////////////////////////////////////
  // reset pin synchronisers; stage one feeds stage two only
  logic [2:0] rst_s1_r;
  logic [2:0] rst_s2_r;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rst_s1_r <= 3'h0;
      rst_s2_r <= 3'h0;
    end else begin
      rst_s1_r <= {flush_reset_n_i, full_reset_n_2_i & full_reset_n_1_i, 1'b1};
      rst_s2_r <= rst_s1_r;
    end
  end
  logic full_n_s;
  logic flush_n_s;
  logic full_n_d_r;
  assign full_n_s  = rst_s2_r[1];
  assign flush_n_s = rst_s2_r[2];
  logic in_reset;
  logic full_rise;
  assign in_reset  = !full_n_s || !flush_n_s || reset_i;
  assign full_rise = full_n_s && !full_n_d_r;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) full_n_d_r <= 1'b0;
    else         full_n_d_r <= full_n_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration captured at full reset release; flush leaves it alone
  frc_prog_t  prog_mode_r;
  logic [1:0] fsel_r;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prog_mode_r  <= FRC_PM_PRESET;
      fsel_r       <= 2'h0;
      big_endian_o <= 1'b0;
    end else if (full_rise) begin
      big_endian_o <= byte_order_timing_sel_i;
      fsel_r       <= {flag_sel1_serial_en_n_i, flag_sel0_serial_data_i};
      if (serial_prog_sel_n_i)
        prog_mode_r <= (flag_sel1_serial_en_n_i | flag_sel0_serial_data_i)
                       ? FRC_PM_PRESET : FRC_PM_PARALLEL;
      else
        prog_mode_r <= FRC_PM_SERIAL;
    end
  end

  // timing mode sampled at the second edge after release
  logic [1:0] rel_cnt_r;
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !full_n_s) begin
      rel_cnt_r           <= 2'h0;
      if (reset_i) fall_through_mode_o <= 1'b0;
    end else if (rel_cnt_r != 2'h2) begin
      rel_cnt_r <= rel_cnt_r + 2'h1;
      if (rel_cnt_r == 2'h1) fall_through_mode_o <= !byte_order_timing_sel_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: reset, settle two cycles, optional programming, run
  frc_state_t state_r;
  logic [1:0]          settle_r;
  logic                prog_done;
  logic [$clog2(SBITS+1)-1:0] sbit_r;
  logic                pwr_r;
  always_ff @(posedge core_clk_i) begin
    if (in_reset) begin
      state_r  <= FRC_S_RESET;
      settle_r <= 2'h0;
    end else begin
      case (state_r)
        FRC_S_RESET: state_r <= FRC_S_SETTLE;
        FRC_S_SETTLE: begin
          settle_r <= settle_r + 2'h1;
          if (settle_r == 2'(`FRC_SYNC_CYC - 1))
            state_r <= (prog_mode_r == FRC_PM_PRESET) ? FRC_S_RUN : FRC_S_PROG;
        end
        FRC_S_PROG: if (prog_done) state_r <= FRC_S_RUN;
        FRC_S_RUN: state_r <= FRC_S_RUN;
        default: state_r <= FRC_S_RESET;
      endcase
    end
  end
  assign prog_done = (prog_mode_r == FRC_PM_SERIAL) ? (sbit_r == SBITS[$bits(sbit_r)-1:0])
                                                    : pwr_r;

  ////////////////////////////////////////////////////////////////////////
  // offset registers: preset, parallel over port a, or serial
  logic [OW-1:0] near_empty_ofs_r;
  logic [OW-1:0] near_full_ofs_r;
  logic          par_idx_r;
  logic          pwrite;
  assign pwrite = state_r == FRC_S_PROG && prog_mode_r == FRC_PM_PARALLEL && port_a_write_i;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      near_empty_ofs_r <= OW'(`FRC_PRESET_OFS_8);
      near_full_ofs_r  <= OW'(`FRC_PRESET_OFS_8);
      par_idx_r        <= 1'b0;
      pwr_r            <= 1'b0;
      sbit_r           <= '0;
    end else if (full_rise) begin
      par_idx_r <= 1'b0;
      pwr_r     <= 1'b0;
      sbit_r    <= '0;
      if (serial_prog_sel_n_i && (flag_sel0_serial_data_i | flag_sel1_serial_en_n_i)) begin
        case ({flag_sel1_serial_en_n_i, flag_sel0_serial_data_i})
          2'h3:    near_empty_ofs_r <= OW'(`FRC_PRESET_OFS_64);
          2'h2:    near_empty_ofs_r <= OW'(`FRC_PRESET_OFS_16);
          default: near_empty_ofs_r <= OW'(`FRC_PRESET_OFS_8);
        endcase
        case ({flag_sel1_serial_en_n_i, flag_sel0_serial_data_i})
          2'h3:    near_full_ofs_r <= OW'(`FRC_PRESET_OFS_64);
          2'h2:    near_full_ofs_r <= OW'(`FRC_PRESET_OFS_16);
          default: near_full_ofs_r <= OW'(`FRC_PRESET_OFS_8);
        endcase
      end
    end else if (pwrite) begin
      // far offset first, then near; the low OW data bits carry the offset, bit OW-1 is the msb
      if (!par_idx_r) near_full_ofs_r <= port_a_data_i[OW-1:0];
      else begin
        near_empty_ofs_r <= port_a_data_i[OW-1:0];
        pwr_r            <= 1'b1;
      end
      par_idx_r <= 1'b1;
    end else if (state_r == FRC_S_PROG && prog_mode_r == FRC_PM_SERIAL &&
                 !flag_sel1_serial_en_n_i && !prog_done) begin
      // one shift register across both offsets, far offset msb enters first
      {near_full_ofs_r, near_empty_ofs_r} <= {near_full_ofs_r[OW-2:0], near_empty_ofs_r,
                                              flag_sel0_serial_data_i};
      sbit_r <= sbit_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stand-in occupancy: axi sets it so thresholds can be exercised
  logic [OW:0] count_r;
  logic        count_wr;
  logic [31:0] wdata_l;
  // flags; reset forces levels, parallel mode raises space before writes
  always_ff @(posedge core_clk_i) begin
    if (in_reset) begin
      flags_o <= '{space_avail_flag:1'b0, data_avail_flag:1'b0, near_empty_flag_n:1'b0,
                   near_full_flag_n:1'b1, mailbox1_full_n:1'b1, mailbox2_full_n:1'b1};
    end else begin
      flags_o.space_avail_flag <= (state_r == FRC_S_RUN ||
                                   (state_r == FRC_S_PROG && prog_mode_r == FRC_PM_PARALLEL))
                                  && count_r < (OW+1)'(DEPTH);
      flags_o.data_avail_flag  <= state_r == FRC_S_RUN && count_r != '0;
      flags_o.near_empty_flag_n <= state_r == FRC_S_RUN && count_r > {1'b0, near_empty_ofs_r};
      flags_o.near_full_flag_n  <= !(state_r == FRC_S_RUN &&
                                     count_r >= (OW+1)'(DEPTH) - {1'b0, near_full_ofs_r});
    end
  end

  // port b output register: zero on any reset, else shows word lane order
  always_ff @(posedge core_clk_i) begin
    if (in_reset) port_b_data_o <= 36'h0;
    else if (count_wr && state_r == FRC_S_RUN) begin
      if (busw_r || !big_endian_o)
        port_b_data_o <= port_a_data_i;
      else
        port_b_data_o <= {port_a_data_i[8:0], port_a_data_i[17:9],
                          port_a_data_i[26:18], port_a_data_i[35:27]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave; one write and one read outstanding
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        busw_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  // one driver for the whole packed response; fields cannot mix drivers
  assign axi_rsp_o = '{awready: !aw_got_r && !bvalid_r, wready: !w_got_r && !bvalid_r,
                       bresp: bresp_r, bvalid: bvalid_r, arready: !rvalid_r,
                       rdata: rdata_r, rresp: rresp_r, rvalid: rvalid_r};
  logic aw_now;
  logic w_now;
  logic [7:0] wa;
  assign aw_now  = aw_got_r || (axi_req_i.awvalid && axi_rsp_o.awready);
  assign w_now   = w_got_r || (axi_req_i.wvalid && axi_rsp_o.wready);
  assign wa      = aw_got_r ? awaddr_r : axi_req_i.awaddr;
  assign wdata_l = w_got_r ? wdata_r : axi_req_i.wdata;
  logic wr_fire;
  assign wr_fire  = aw_now && w_now && !axi_rsp_o.bvalid;
  assign count_wr = wr_fire && wa == `FRC_ADDR_COUNT;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= `FRC_AXI_OKAY;
      busw_r   <= 1'b0;
      count_r  <= '0;
    end else begin
      if (axi_req_i.awvalid && axi_rsp_o.awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= axi_req_i.awaddr;
      end
      if (axi_req_i.wvalid && axi_rsp_o.wready) begin
        w_got_r <= 1'b1;
        wdata_r <= axi_req_i.wdata;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= (wa == `FRC_ADDR_CTRL || wa == `FRC_ADDR_COUNT)
                    ? `FRC_AXI_OKAY : `FRC_AXI_SLVERR;
        if (wa == `FRC_ADDR_CTRL) busw_r <= wdata_l[`FRC_CTRL_BUSW];
      end else if (bvalid_r && axi_req_i.bready)
        bvalid_r <= 1'b0;
      if (in_reset) count_r <= '0;
      else if (count_wr) count_r <= wdata_l[OW:0];
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= `FRC_AXI_OKAY;
    end else if (axi_req_i.arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `FRC_AXI_OKAY;
      case (axi_req_i.araddr)
        `FRC_ADDR_CTRL:    rdata_r <= {30'h0, busw_r, 1'b0};
        `FRC_ADDR_STATUS:  rdata_r <= {22'h0, prog_mode_r == FRC_PM_SERIAL,
                                               state_r == FRC_S_PROG, big_endian_o,
                                               fall_through_mode_o, flags_o.mailbox2_full_n,
                                               flags_o.mailbox1_full_n, flags_o.near_full_flag_n,
                                               flags_o.near_empty_flag_n,
                                               flags_o.data_avail_flag, flags_o.space_avail_flag};
        `FRC_ADDR_OFFSETS: rdata_r <= {2'h0, 14'(near_full_ofs_r),
                                       2'h0, 14'(near_empty_ofs_r)};
        `FRC_ADDR_COUNT:   rdata_r <= 32'(count_r);
        default: begin
          rdata_r <= 32'h0;
          rresp_r <= `FRC_AXI_SLVERR;
        end
      endcase
    end else if (rvalid_r && axi_req_i.rready)
      rvalid_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  space_low_rst_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    in_reset |=> !flags_o.space_avail_flag) else $error("space flag high in reset");
  mbox_high_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    in_reset |=> flags_o.mailbox1_full_n && flags_o.mailbox2_full_n)
    else $error("mailbox flags low in reset");
  space_after_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(flags_o.space_avail_flag)
    |-> !$past(in_reset, 1) && !$past(in_reset, 2))
    else $error("space flag rose too early");
  portb_zero_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    in_reset |=> port_b_data_o == 36'h0) else $error("port b not cleared");
  serial_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state_r == FRC_S_PROG && prog_mode_r == FRC_PM_SERIAL |=> !flags_o.space_avail_flag)
    else $error("space flag high during serial load");
  mode_pick_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    full_rise ##1 !in_reset |=> fall_through_mode_o == !$past(byte_order_timing_sel_i))
    else $error("timing mode not sampled");
  ne_level_a: assert property (@(posedge core_clk_i) disable iff (reset_i || in_reset)
    state_r == FRC_S_RUN && $stable(count_r) && count_r <= {1'b0, near_empty_ofs_r}
    |=> !flags_o.near_empty_flag_n) else $error("near empty flag wrong");
  ofs_keep_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !flush_n_s && full_n_s && !full_rise |=> $stable(near_empty_ofs_r))
    else $error("flush changed offsets");
  cov_serial_c: cover property (@(posedge core_clk_i) state_r == FRC_S_PROG
    && prog_mode_r == FRC_PM_SERIAL ##1 state_r == FRC_S_RUN);
  cov_par_c: cover property (@(posedge core_clk_i) pwrite && par_idx_r);
  cov_flush_c: cover property (@(posedge core_clk_i) !flush_n_s && state_r == FRC_S_RESET);
endmodule
`default_nettype wire

// ===== test/frc_host_model.sv
// Purpose: host logic that drives the reset, mode and programming pins
// Assumes: pins change by nonblocking assignment just after a rising edge
// Notes:   behavioural; the bench calls its tasks, released data shows inverted
`timescale 1ns/1ps
`default_nettype none
module frc_host_model (
  input  wire logic        core_clk_i,
  output var  logic        full_reset_n_1_o,
  output var  logic        full_reset_n_2_o,
  output var  logic        flush_reset_n_o,
  output var  logic        order_sel_o,
  output var  logic        sd_o,
  output var  logic        en_n_o,
  output var  logic        spm_n_o,
  output var  logic        write_o,
  output var  logic [35:0] data_o
);
  //////////////////////////////////////////////////////////////////////////
  // power-up: full reset already held low before anything is written
  initial begin
    full_reset_n_1_o = 1'b0;
    full_reset_n_2_o = 1'b0;
    flush_reset_n_o  = 1'b1;
    order_sel_o      = 1'b1;
    sd_o             = 1'b0;
    en_n_o           = 1'b1;
    spm_n_o          = 1'b1;
    write_o          = 1'b0;
    data_o           = 36'h0;
  end

  //////////////////////////////////////////////////////////////////////////
  // full reset: six edges low, then order pin moves to the mode level for good
  task automatic full_reset(input logic be, input logic mode, input logic spm_n,
                            input logic fs0, input logic fs1);
    @(posedge core_clk_i);
    full_reset_n_1_o <= 1'b0;
    full_reset_n_2_o <= 1'b0;
    order_sel_o      <= be;
    sd_o             <= fs0;
    en_n_o           <= fs1;
    spm_n_o          <= spm_n;
    repeat (6) @(posedge core_clk_i);
    full_reset_n_1_o <= 1'b1;
    full_reset_n_2_o <= 1'b1;
    // order level held three more edges: the release reaches the capture
    // register only after the two-flop synchroniser and the edge detector
    repeat (3) @(posedge core_clk_i);
    order_sel_o <= mode;
  endtask

  // flush reset held past the minimum width
  task automatic flush();
    @(posedge core_clk_i);
    flush_reset_n_o <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    flush_reset_n_o <= 1'b1;
  endtask

  // one port a write pulse, data inverted once released
  task automatic write_a(input logic [35:0] d);
    @(posedge core_clk_i);
    write_o <= 1'b1;
    data_o  <= d;
    @(posedge core_clk_i);
    write_o <= 1'b0;
    data_o  <= ~d;
  endtask

  // serial stream, one bit per edge with enable low, msb first
  task automatic shift(input logic [19:0] v);
    for (int i = 19; i >= 0; i--) begin
      @(posedge core_clk_i);
      sd_o   <= v[i];
      en_n_o <= 1'b0;
    end
    @(posedge core_clk_i);
    en_n_o <= 1'b1;
    sd_o   <= ~v[0];
  endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// Purpose: self-checking bench for the fifo reset and offset block
// Assumes: depth 1024, so offsets are 10 bits and the stream is 20 bits
// Notes:   pins come from the host model, registers over axi4-lite
`include "frc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import frc_pkg::*;
  logic         core_clk;
  logic         reset;
  frc_axi_req_t req;
  frc_axi_rsp_t rsp;
  frc_flags_t   flags;
  logic         fall_thr;
  logic         big_end;
  logic [35:0]  port_b;
  wire  logic   rst1, rst2, flush_n, order, sd, en_n, spm_n, wr;
  wire  logic [35:0] wdat;
  logic [31:0]  rd;
  logic [1:0]   rs;
  int           error_cnt;
  int           n_compared;
  int           cyc;

  frc_host_model host (.core_clk_i(core_clk), .full_reset_n_1_o(rst1),
    .full_reset_n_2_o(rst2), .flush_reset_n_o(flush_n), .order_sel_o(order), .sd_o(sd),
    .en_n_o(en_n), .spm_n_o(spm_n), .write_o(wr), .data_o(wdat));

  frc_reset_cfg #(.DEPTH(1024)) DUT (.core_clk_i(core_clk), .reset_i(reset),
    .full_reset_n_1_i(rst1), .full_reset_n_2_i(rst2), .flush_reset_n_i(flush_n),
    .byte_order_timing_sel_i(order), .flag_sel0_serial_data_i(sd),
    .flag_sel1_serial_en_n_i(en_n), .serial_prog_sel_n_i(spm_n), .port_a_write_i(wr),
    .port_a_data_i(wdat), .axi_req_i(req), .axi_rsp_o(rsp), .flags_o(flags),
    .fall_through_mode_o(fall_thr), .big_endian_o(big_end), .port_b_data_o(port_b));

  //////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      error_cnt++;
    end
  endtask

  // one write or read; handshakes judged at the falling edge, taken at the next rise
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hr;
    int   t;
    t = 0;
    hr = 1'b0;
    @(posedge core_clk);
    if (w) begin
      req.awaddr  <= a;
      req.awvalid <= 1'b1;
      req.wdata   <= d;
      req.wvalid  <= 1'b1;
      req.bready  <= 1'b1;
    end else begin
      req.araddr  <= a;
      req.arvalid <= 1'b1;
      req.rready  <= 1'b1;
    end
    while (!hr && t < 100) begin
      @(negedge core_clk);
      ha = w ? (req.awvalid & rsp.awready) === 1'b1 : (req.arvalid & rsp.arready) === 1'b1;
      hw = (req.wvalid & rsp.wready) === 1'b1;
      hr = w ? (rsp.bvalid & req.bready) === 1'b1 : (rsp.rvalid & req.rready) === 1'b1;
      rd = rsp.rdata;
      rs = w ? rsp.bresp : rsp.rresp;
      @(posedge core_clk);
      t++;
      if (ha) begin
        req.awvalid <= 1'b0;
        req.arvalid <= 1'b0;
      end
      if (hw) req.wvalid <= 1'b0;
      if (hr) begin
        req.bready <= 1'b0;
        req.rready <= 1'b0;
      end
    end
    chk("bus answer", 36'h1, {35'h0, hr});
  endtask

  // bounded wait for the space flag
  task automatic wait_space(input int n);
    int t;
    t = 0;
    while (flags.space_avail_flag !== 1'b1 && t < n) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    chk("space flag", 36'h1, {35'h0, flags.space_avail_flag});
  endtask

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // preset 64, big order, fall-through mode
  task automatic s_preset();
    fork
      host.full_reset(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      begin
        repeat (5) @(posedge core_clk);
        #1 chk("flags in reset", 36'h07, 36'(flags));
      end
    join
    wait_space(8);
    repeat (3) @(posedge core_clk);
    #1 chk("big order", 36'h1, {35'h0, big_end});
    chk("fall through", 36'h1, {35'h0, fall_thr});
    axi(1'b0, `FRC_ADDR_OFFSETS, 32'h0);
    chk("preset offsets", 36'h0040_0040, {4'h0, rd});
  endtask

  // flush keeps offsets and mode, zeroes port b
  task automatic s_flush();
    fork
      host.flush();
      begin
        repeat (5) @(posedge core_clk);
        #1 chk("flags in flush", 36'h07, 36'(flags));
        chk("port b cleared", 36'h0, port_b);
      end
    join
    wait_space(8);
    axi(1'b0, `FRC_ADDR_OFFSETS, 32'h0);
    chk("offsets kept", 36'h0040_0040, {4'h0, rd});
    chk("mode kept", 36'h1, {35'h0, fall_thr});
  endtask

  // parallel load: far offset then near, boundary values
  task automatic s_parallel();
    host.full_reset(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    wait_space(8);
    host.write_a(36'h3FF);
    host.write_a(36'h0);
    axi(1'b0, `FRC_ADDR_OFFSETS, 32'h0);
    chk("parallel offsets", 36'h03FF_0000, {4'h0, rd});
    chk("little order", 36'h0, {35'h0, big_end});
    chk("standard mode", 36'h0, {35'h0, fall_thr});
  endtask

  // serial load 005 / 2AA, then near-empty threshold via the count stand-in
  task automatic s_serial();
    host.full_reset(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    repeat (8) @(posedge core_clk);
    #1 chk("space before stream", 36'h0, {35'h0, flags.space_avail_flag});
    host.shift(20'h016AA);
    wait_space(3);
    axi(1'b0, `FRC_ADDR_OFFSETS, 32'h0);
    chk("serial offsets", 36'h0005_02AA, {4'h0, rd});
    axi(1'b1, `FRC_ADDR_COUNT, 32'h2AA);
    repeat (3) @(posedge core_clk);
    #1 chk("near empty at offset", 36'h0, {35'h0, flags.near_empty_flag_n});
    axi(1'b1, `FRC_ADDR_COUNT, 32'h2AB);
    repeat (3) @(posedge core_clk);
    #1 chk("near empty above", 36'h1, {35'h0, flags.near_empty_flag_n});
  endtask

  // unmapped address refused both ways
  task automatic s_unmapped();
    axi(1'b0, 8'h40, 32'h0);
    chk("bad read resp", 36'(`FRC_AXI_SLVERR), {34'h0, rs});
    chk("bad read data", 36'h0, {4'h0, rd});
    axi(1'b1, 8'h40, 32'h5A5A_5A5A);
    chk("bad write resp", 36'(`FRC_AXI_SLVERR), {34'h0, rs});
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    req = '0;
    req.wstrb = 4'hF;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    s_preset();
    s_flush();
    s_parallel();
    s_serial();
    s_unmapped();
    results();
  end
endmodule
`default_nettype wire
